// File: itx_defs.vh
`ifndef ITX_DEFS_VH
`define ITX_DEFS_VH
// register byte offsets
`define ITX_OFF_ACK       8'h2c
`define ITX_OFF_ENA       8'h30
`define ITX_OFF_CTL       8'h34
`define ITX_OFF_MEM       8'h38
// reset values
`define ITX_ACK_RST       32'h0000_0000
`define ITX_ENA_RST       32'h0000_0000
`define ITX_CTL_RST       32'h0000_0000
`define ITX_MEM_RST       32'h0000_0003
// interrupt acknowledge bit positions
`define ITX_B_CIPHER_FAULT 14
`define ITX_B_KEY_SWAP     13
`define ITX_B_COPY_CHANGE  12
`define ITX_B_NEAR_FULL    9
`define ITX_B_MID_FULL     8
`define ITX_B_FAR_FULL     7
`define ITX_B_STAMP_SENT   6
`define ITX_B_PAYLOAD_DONE 5
`define ITX_B_BLOCK_LOSS   4
`define ITX_B_INPUT_FAULT  3
`define ITX_B_LOST_CYCLE   2
`define ITX_B_BANK_FULL    1
`define ITX_B_BANK_EMPTY   0
// writable mask of the acknowledge register (bits 14..12, 9..0)
`define ITX_ACK_MASK      32'h0000_73ff
`define ITX_ENA_MASK      32'h0000_3fff
// control register fields
`define ITX_C_CIPHER_EN   20
`define ITX_C_PIN_EN      19
`define ITX_C_TAG_HI      15
`define ITX_C_TAG_LO      14
`define ITX_C_CHAN_HI     13
`define ITX_C_CHAN_LO     8
`define ITX_C_SPEED_HI    5
`define ITX_C_SPEED_LO    4
`define ITX_C_COPY_HI     3
`define ITX_C_COPY_LO     2
`define ITX_C_PARITY      1
`define ITX_C_SYNC        0
// storable control bits (sync code bit 0 is hardware-owned)
`define ITX_CTL_MASK      32'h0018_ff3e
// queue free-space thresholds in quadlets
`define ITX_FREE_100      12'h064
`define ITX_FREE_256      12'h100
`define ITX_FREE_512      12'h200
`define ITX_FREE_FIVE     12'h005
`define ITX_FREE_ONE      12'h001
// cipher throughput ceiling in Mbit/s, as a bound the data side must respect
`define ITX_CIPHER_MBPS   60
`endif

// File: itx_regs.v
// Notes on behaviour
// R1: flags 2,3,4 self-recover; host still clears them
// R2: cipher fault sets bit 14
// R3: key swap done sets bit 13
// R4: copy level change sets bit 12
// R5: bits 9,8,7 at 100,256,512 free
// R6: 512 flag disabled for half-kilobyte buffer
// R7: stamp sent in header sets bit 6
// R8: payload done or discarded sets bit 5
// R9: bits 4,3,2 block loss, input, lost cycle
// R10: bank full sets bit 1, resets transmitter
// R11: bank empty sets bit 0
// R12: enable bits 13..0, reset zero
// R13: cipher enable; key follows copy level
// R14: cipher average rate at most 60 Mbps
// R15: bits 15..14 form header tag
// R16: bits 13..8 form channel number
// R17: bits 5..4 select transmit speed
// R18: copy field tracks pins when pin-enable set
// R19: parity write swaps key next packet
// R20: cipher off: parity is plain storage
// R21: sync code follows its payload
// R22: read-only buffer status, reset value three
// R23: irq when enabled acknowledge bit set
// R24: host disables, drains, then resets transmitter
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "itx_defs.vh"

module itx_regs #(
    parameter FREE_W = 12                   // width of free-space count
)(
    // clock and reset
    input  wire              clk,
    input  wire              rst_n,
    // register port
    input  wire [7:0]        reg_addr,
    input  wire [31:0]       reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [31:0]       reg_rdata,
    // queue state from the transmit memory
    input  wire [FREE_W-1:0] queue_free,
    input  wire              queue_full,
    input  wire              queue_empty,
    input  wire              half_k_buffer,
    // events from the data path
    input  wire              cipher_fault_evt,
    input  wire              stamp_sent_evt,
    input  wire              payload_done_evt,
    input  wire              block_loss_evt,
    input  wire              input_fault_evt,
    input  wire              lost_cycle_evt,
    input  wire              packet_start,
    // application pins
    input  wire [1:0]        copy_level_pins,
    input  wire              sync_code_pin,
    input  wire              sync_code_valid,
    // header, cipher and reset controls to the data path, and the interrupt request
    output reg               cipher_enable,
    output reg  [1:0]        hdr_tag,
    output reg  [5:0]        hdr_channel,
    output reg  [1:0]        tx_speed,
    output reg  [1:0]        cipher_copy_level,
    output reg               cipher_key_parity,
    output reg               hdr_key_parity,
    output reg               hdr_sync_code,
    output reg               iso_transmitter_reset,
    output wire              tx_irq
);

    // software-visible and internal state
    reg  [31:0] tx_interrupt_ack;           // sticky event flags
    reg  [31:0] tx_interrupt_enable;        // per-flag enable, none for the cipher fault flag
    reg  [31:0] tx_control;                 // stored control bits
    reg  [31:0] tx_memory_status;           // registered buffer status
    reg  [1:0]  copy_pin_q;                 // registered copy pins
    reg         pend_key_swap;              // key swap waiting for next packet
    reg         pend_copy_swap;             // copy change waiting for next packet
    reg  [2:0]  prev_levels;                // previous threshold levels
    reg         prev_full;                  // previous full level
    reg         prev_empty;                 // previous empty level

    // decoded accesses
    wire wr_ack = reg_wr && (reg_addr == `ITX_OFF_ACK);
    wire wr_ena = reg_wr && (reg_addr == `ITX_OFF_ENA);
    wire wr_ctl = reg_wr && (reg_addr == `ITX_OFF_CTL);

    // copy level in force: pins or stored field
    wire [1:0] copy_now = tx_control[`ITX_C_PIN_EN] ? copy_pin_q            // [R18]
                        : tx_control[`ITX_C_COPY_HI:`ITX_C_COPY_LO];

    // threshold levels: 100, 256, 512 quadlets or fewer free
    wire lvl_100 = (queue_free <= `ITX_FREE_100);
    wire lvl_256 = (queue_free <= `ITX_FREE_256);
    wire lvl_512 = (queue_free <= `ITX_FREE_512) && !half_k_buffer;    // [R6]
    wire [2:0] levels = {lvl_100, lvl_256, lvl_512};

    // parity write that changes the bit while ciphering
    wire parity_flip = wr_ctl && tx_control[`ITX_C_CIPHER_EN]
                     && (reg_wdata[`ITX_C_PARITY] != tx_control[`ITX_C_PARITY]);

    // copy level change seen by the cipher
    wire copy_change = tx_control[`ITX_C_CIPHER_EN] && (copy_now != cipher_copy_level);

    // key swap completes on a packet boundary
    wire key_swap_done = packet_start && (pend_key_swap || pend_copy_swap);

    // collected events, one bit per flag
    // level-type sources (thresholds, full, empty) are turned into edges here,
    // so a queue that sits at a threshold raises its flag only once; software
    // clearing the flag while the level stays high is not re-notified until
    // the level has dropped and risen again
    // pulse-type sources come straight from the data path and must be one
    // cycle wide, otherwise a clear in the middle of a long pulse is lost
    reg [31:0] events;

    // event vector from edges and pulses
    always @*
    begin
        events = 32'h0000_0000;
        events[`ITX_B_CIPHER_FAULT] = cipher_fault_evt;                 // [R2]
        events[`ITX_B_KEY_SWAP]     = key_swap_done;                    // [R3]
        events[`ITX_B_COPY_CHANGE]  = copy_change;                      // [R4]
        events[`ITX_B_NEAR_FULL]    = levels[2] && !prev_levels[2];     // [R5]
        events[`ITX_B_MID_FULL]     = levels[1] && !prev_levels[1];     // [R5]
        events[`ITX_B_FAR_FULL]     = levels[0] && !prev_levels[0];     // [R5]
        events[`ITX_B_STAMP_SENT]   = stamp_sent_evt;                   // [R7]
        events[`ITX_B_PAYLOAD_DONE] = payload_done_evt;                 // [R8]
        events[`ITX_B_BLOCK_LOSS]   = block_loss_evt;                   // [R9]
        events[`ITX_B_INPUT_FAULT]  = input_fault_evt;                  // [R9]
        events[`ITX_B_LOST_CYCLE]   = lost_cycle_evt;                   // [R9]
        events[`ITX_B_BANK_FULL]    = queue_full && !prev_full;         // [R10]
        events[`ITX_B_BANK_EMPTY]   = queue_empty && !prev_empty;       // [R11]
    end

    // acknowledge flags: software writes a one to clear, a new event wins
    // flags 2..4 only inform; the data path recovers on its own [R1]
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            tx_interrupt_ack <= `ITX_ACK_RST;
        end
        else
        begin
            tx_interrupt_ack <= ((tx_interrupt_ack & ~(wr_ack ? reg_wdata : 32'h0000_0000))
                                | events) & `ITX_ACK_MASK;          // [R1]
        end
    end

    // enable register, bits 13..0 only
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            tx_interrupt_enable <= `ITX_ENA_RST;
        end
        else if (wr_ena)
        begin
            tx_interrupt_enable <= reg_wdata & `ITX_ENA_MASK;       // [R12]
        end
    end

    // control register; copy field frozen while pins drive it
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            tx_control <= `ITX_CTL_RST;
        end
        else if (wr_ctl)
        begin
            tx_control <= reg_wdata & `ITX_CTL_MASK;                // [R15] [R16] [R17]
            if (tx_control[`ITX_C_PIN_EN] && reg_wdata[`ITX_C_PIN_EN])
            begin
                // read-only while pins are enabled
                tx_control[`ITX_C_COPY_HI:`ITX_C_COPY_LO] <=
                    tx_control[`ITX_C_COPY_HI:`ITX_C_COPY_LO];      // [R18]
            end
        end
    end

    // cipher key state: level moves on a copy change, parity on a packet start with a key swap pending or whenever the cipher is off
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            cipher_copy_level <= 2'h0;
            cipher_key_parity <= 1'b0;
            pend_key_swap     <= 1'b0;
            pend_copy_swap    <= 1'b0;
        end
        else
        begin
            // new level noted at once, key switched on the next packet
            if (copy_change)
            begin
                cipher_copy_level <= copy_now;                       // [R13]
                pend_copy_swap    <= 1'b1;
            end
            else if (packet_start)
            begin
                pend_copy_swap <= 1'b0;
            end
            // parity flip arms a swap; a flip in the same cycle as a packet waits one more
            if (parity_flip)
            begin
                pend_key_swap <= 1'b1;                               // [R19]
            end
            else if (packet_start)
            begin
                pend_key_swap <= 1'b0;
            end
            if (packet_start && pend_key_swap)
            begin
                cipher_key_parity <= tx_control[`ITX_C_PARITY];      // [R19]
            end
            else if (!tx_control[`ITX_C_CIPHER_EN])
            begin
                cipher_key_parity <= tx_control[`ITX_C_PARITY];      // [R20]
            end
        end
    end

    // header fields, registered; rate limit is the data path's pacing [R14]
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            cipher_enable  <= 1'b0;
            hdr_tag        <= 2'h0;
            hdr_channel    <= 6'h00;
            tx_speed       <= 2'h0;
            hdr_key_parity <= 1'b0;
            hdr_sync_code  <= 1'b0;
            copy_pin_q     <= 2'h0;
        end
        else
        begin
            cipher_enable  <= tx_control[`ITX_C_CIPHER_EN];          // [R13]
            hdr_tag        <= tx_control[`ITX_C_TAG_HI:`ITX_C_TAG_LO];      // [R15]
            hdr_channel    <= tx_control[`ITX_C_CHAN_HI:`ITX_C_CHAN_LO];    // [R16]
            tx_speed       <= tx_control[`ITX_C_SPEED_HI:`ITX_C_SPEED_LO];  // [R17]
            hdr_key_parity <= tx_control[`ITX_C_CIPHER_EN] ? cipher_key_parity
                            : tx_control[`ITX_C_PARITY];             // [R20]
            copy_pin_q     <= copy_level_pins;                       // [R18]
            // sync code caught with the payload word it came with
            if (sync_code_valid)
            begin
                hdr_sync_code <= sync_code_pin;                      // [R21]
            end
        end
    end

    // buffer status and previous levels for edge detection
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            tx_memory_status      <= `ITX_MEM_RST;
            prev_levels           <= 3'b000;
            prev_full             <= 1'b0;
            prev_empty            <= 1'b1;
            iso_transmitter_reset <= 1'b0;
        end
        else
        begin
            tx_memory_status <= {25'h000_0000, lvl_100, lvl_256,
                                 (queue_free <= `ITX_FREE_512),
                                 queue_full,
                                 (queue_free == `ITX_FREE_ONE),
                                 (queue_free >= `ITX_FREE_FIVE),
                                 queue_empty};                       // [R22]
            prev_levels      <= levels;
            prev_full        <= queue_full;
            prev_empty       <= queue_empty;
            // a full bank is fatal: one-cycle self reset of the transmitter
            iso_transmitter_reset <= queue_full && !prev_full;       // [R10]
        end
    end

    // interrupt request: any enabled flag
    // kept combinational so a clear or a mask write drops it in the same
    // cycle the register changes; the enable has no bit for the cipher
    // fault flag, so that flag is only seen by polling
    assign tx_irq = |(tx_interrupt_ack & tx_interrupt_enable);       // [R23]

    // read data one cycle after the strobe; unmapped reads give zero
    // the bus is driven to zero outside the read slot so that several
    // register blocks can be or-ed onto one return path without a mux
    // host-side reset ordering [R24] is left to software
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 32'h0000_0000;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                `ITX_OFF_ACK: reg_rdata <= tx_interrupt_ack;
                `ITX_OFF_ENA: reg_rdata <= tx_interrupt_enable;
                `ITX_OFF_CTL: reg_rdata <= {tx_control[31:4], copy_now,
                                            tx_control[1], hdr_sync_code};
                `ITX_OFF_MEM: reg_rdata <= tx_memory_status;
                default:      reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
        begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// File: itx_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "itx_defs.vh"
module itx_regs_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // data side inputs
    input wire logic        queue_full,
    input wire logic        sync_code_pin,
    input wire logic        sync_code_valid,
    // outputs under watch
    input wire logic        cipher_enable,
    input wire logic [1:0]  hdr_tag,
    input wire logic [5:0]  hdr_channel,
    input wire logic [1:0]  tx_speed,
    input wire logic        hdr_key_parity,
    input wire logic        hdr_sync_code,
    input wire logic        iso_transmitter_reset,
    input wire logic        tx_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // one read slot, and a control write
    sequence rd_s(a); reg_rd && reg_addr == a; endsequence
    sequence ctl_wr_s; reg_wr && reg_addr == `ITX_OFF_CTL; endsequence
    ena_rsvd_a: assert property (rd_s(`ITX_OFF_ENA) |=> reg_rdata[31:14] == 18'h0_0000)
        else $error("enable upper bits not zero");
    mem_rsvd_a: assert property (rd_s(`ITX_OFF_MEM) |=> reg_rdata[31:7] == 25'h000_0000)
        else $error("status upper bits not zero");
    // outputs copy the stored control word, so they show the write two edges later
    ctl_apply_a: assert property (ctl_wr_s |-> ##2 hdr_tag == $past(reg_wdata[15:14], 2)
        && hdr_channel == $past(reg_wdata[13:8], 2) && tx_speed == $past(reg_wdata[5:4], 2)
        && cipher_enable == $past(reg_wdata[20], 2)) else $error("control fields not applied");
    parity_plain_a: assert property (ctl_wr_s ##0 !reg_wdata[20] |-> ##2
        hdr_key_parity == $past(reg_wdata[1], 2)) else $error("header parity wrong");
    sync_follow_a: assert property (sync_code_valid |=>
        hdr_sync_code == $past(sync_code_pin)) else $error("sync code not taken");
    full_reset_a: assert property ($rose(queue_full) |=> iso_transmitter_reset)
        else $error("no transmitter reset on full");
    reset_cause_a: assert property (iso_transmitter_reset |->
        $past(queue_full) && !$past(queue_full, 2)) else $error("stray transmitter reset");
    irq_mask_a: assert property (reg_wr && reg_addr == `ITX_OFF_ENA
        && reg_wdata == 32'h0000_0000 |=> !tx_irq) else $error("irq with all masked");
endmodule
`default_nettype wire

// File: itx_app_model.sv
`timescale 1ns/1ns
`default_nettype none
module itx_app_model #(
    parameter DEPTH = 1024                 // queue size in quadlets
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // commands from the bench
    input  wire logic [11:0] fill_level,
    input  wire logic [6:0]  evt_req,
    // queue state and event pulses
    output logic [11:0]      queue_free,
    output logic             queue_full,
    output logic             queue_empty,
    output logic [6:0]       evt_pulse
);
    // levels and free count are registered together, one cycle behind the bench's fill level
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            queue_free  <= DEPTH[11:0];
            queue_full  <= 1'b0;
            queue_empty <= 1'b1;
            evt_pulse   <= 7'h00;
        end
        else
        begin
            queue_free  <= DEPTH[11:0] - fill_level;
            queue_full  <= fill_level == DEPTH[11:0];
            queue_empty <= fill_level == 12'h000;
            evt_pulse   <= evt_req;  // one-cycle pulses only
        end
    end
endmodule
`default_nettype wire

// File: itx_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "itx_defs.vh"
module itx_regs_tb;
    logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic [11:0] fill_level = 0, queue_free;
    logic [6:0]  evt_req = 0, evt_pulse;
    logic        queue_full, queue_empty, half_k = 0, sync_pin = 0, sync_vld = 0;
    logic [1:0]  pins = 0, tag, speed, copy_lvl;
    logic [5:0]  chan;
    logic        cen, cpar, hpar, hsync, txrst, irq;
    int          mismatches = 0, samples_checked = 0;
    always #5 clk = ~clk;
    itx_app_model itx_app_model_inst (.clk, .rst_n, .fill_level, .evt_req, .queue_free,
        .queue_full, .queue_empty, .evt_pulse);
    itx_regs itx_regs_inst (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .queue_free, .queue_full, .queue_empty, .half_k_buffer(half_k),
        .cipher_fault_evt(evt_pulse[0]), .stamp_sent_evt(evt_pulse[1]),
        .payload_done_evt(evt_pulse[2]), .block_loss_evt(evt_pulse[3]),
        .input_fault_evt(evt_pulse[4]), .lost_cycle_evt(evt_pulse[5]),
        .packet_start(evt_pulse[6]), .copy_level_pins(pins), .sync_code_pin(sync_pin),
        .sync_code_valid(sync_vld), .cipher_enable(cen), .hdr_tag(tag), .hdr_channel(chan),
        .tx_speed(speed), .cipher_copy_level(copy_lvl), .cipher_key_parity(cpar),
        .hdr_key_parity(hpar), .hdr_sync_code(hsync), .iso_transmitter_reset(txrst),
        .tx_irq(irq));
    // compare and count
    task check(input [31:0] seen, input [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
        #1;
    endtask
    // data stand only in the cycle after the read strobe
    task rd(input [7:0] a, input [31:0] exp);
        @(posedge clk);
        reg_rd <= 1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1 check(reg_rdata, exp);
    endtask
    task pulse(input [6:0] v);
        @(posedge clk);
        evt_req <= v;
        @(posedge clk);
        evt_req <= 0;
        repeat (3) @(posedge clk);
    endtask
    task fill(input [11:0] f);
        @(posedge clk);
        fill_level <= f;
        repeat (4) @(posedge clk);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out;
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        rd(`ITX_OFF_ACK, 32'h0000_0000);
        rd(`ITX_OFF_ENA, 32'h0000_0000);
        rd(`ITX_OFF_CTL, 32'h0000_0000);
        rd(`ITX_OFF_MEM, 32'h0000_0003);
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, 32'h0000_0000);
        wr(`ITX_OFF_ENA, 32'hffff_ffff);
        rd(`ITX_OFF_ENA, 32'h0000_3fff);
        $display("registers done");
        for (int i = 0; i < 6; i++) pulse(7'(1 << i));
        rd(`ITX_OFF_ACK, 32'h0000_407c);
        check({31'h0, irq}, 32'h0000_0001);
        wr(`ITX_OFF_ENA, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
        wr(`ITX_OFF_ACK, 32'h0000_407c);
        rd(`ITX_OFF_ACK, 32'h0000_0000);
        $display("events done");
        fill(12'd924);
        rd(`ITX_OFF_MEM, 32'h0000_0072);
        rd(`ITX_OFF_ACK, 32'h0000_0380);
        wr(`ITX_OFF_ACK, 32'h0000_0380);
        half_k <= 1;
        fill(12'd0);
        fill(12'd924);
        rd(`ITX_OFF_ACK, 32'h0000_0301);
        wr(`ITX_OFF_ACK, 32'h0000_0301);
        fill(12'd1024);
        rd(`ITX_OFF_MEM, 32'h0000_0078);
        rd(`ITX_OFF_ACK, 32'h0000_0002);
        fill(12'd1023);
        rd(`ITX_OFF_MEM, 32'h0000_0074);
        wr(`ITX_OFF_ACK, 32'h0000_73ff);
        $display("queue done");
        for (int s = 0; s < 4; s++)
        begin
            wr(`ITX_OFF_CTL, 32'h0000_4000 | (s << 4));
            @(posedge clk);
            #1 check({30'h0, speed}, s);
        end
        wr(`ITX_OFF_CTL, 32'h0000_7f3e);
        @(posedge clk);
        #1 check({24'h0, tag, chan}, 32'h0000_007f);
        check({31'h0, hpar}, 32'h0000_0001);
        rd(`ITX_OFF_CTL, 32'h0000_7f3e);
        pins <= 2'b10;
        wr(`ITX_OFF_CTL, 32'h0008_0000);
        rd(`ITX_OFF_CTL, 32'h0008_0008);
        wr(`ITX_OFF_CTL, 32'h0018_0000);
        pins <= 2'b01;
        pulse(7'h00);
        pulse(7'h40);
        check({30'h0, copy_lvl}, 32'h0000_0001);
        rd(`ITX_OFF_ACK, 32'h0000_3000);
        sync_pin <= 1; sync_vld <= 1;
        @(posedge clk);
        sync_vld <= 0;
        @(posedge clk);
        #1 check({31'h0, hsync}, 32'h0000_0001);
        // host side reset order: disable, drain, then the bank reads empty
        wr(`ITX_OFF_CTL, 32'h0000_0000);
        fill(12'd0);
        rd(`ITX_OFF_MEM, 32'h0000_0003);
        $display("control done");
        close_out;
    end
endmodule
bind itx_regs itx_regs_checker itx_regs_checker_inst (.clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .queue_full, .sync_code_pin,
    .sync_code_valid, .cipher_enable, .hdr_tag, .hdr_channel, .tx_speed,
    .hdr_key_parity, .hdr_sync_code, .iso_transmitter_reset, .tx_irq);
`default_nettype wire
